// ---- include/rcrix_pkg.sv ----
/*
 Package for the relative call / reset / indexed operation executer.
 Holds opcode patterns, field positions, reset values and flag layout.
 Assumes a 16-bit instruction word and a 12-bit data address space.
*/
package rcrix_pkg;
	localparam int PC_W = 21;
	localparam int DA_W = 12;
	localparam logic [4:0] OP_REL_CALL = 5'h1b;
	localparam logic [15:0] OP_RESET = 16'h00ff;
	localparam logic [5:0] OP_ADD_IDX = 6'h09;
	localparam logic [7:0] OP_FILL_ONES = 8'h68;
	localparam logic [3:0] OP_BIT_SET = 4'h8;
	localparam logic [5:0] OP_DEC_SKIP_Z = 6'h0b;
	localparam logic [5:0] OP_DEC_SKIP_NZ = 6'h13;
	localparam logic [7:0] IDX_LIMIT = 8'h5f;
	localparam logic [7:0] ALL_ONES = 8'hff;
	localparam logic [PC_W-1:0] PC_RESET = 21'h0;
	localparam logic [7:0] W_RESET = 8'h00;
	localparam logic [4:0] FLAGS_RESET = 5'h00;
	localparam int FLAG_C = 0;
	localparam int FLAG_DC = 1;
	localparam int FLAG_Z = 2;
	localparam int FLAG_OV = 3;
	localparam int FLAG_N = 4;

	typedef struct packed {
		logic we;
		logic [DA_W-1:0] addr;
		logic [7:0] wdata;
	} rcrix_dmem_type;

	typedef struct packed {
		logic push;
		logic [PC_W-1:0] value;
	} rcrix_stack_type;
endpackage

// ---- hw/rcrix_exec.sv ----
/*
 Execution unit for relative call, software reset, indexed literal offset
 add/bit-set/fill and decrement-and-skip.
 Assumes instruction words arrive with a valid strobe each cycle from a
 fetch stage on ref_clk, and data memory reads are combinational.
*/
`timescale 1ns/1ps
module rcrix_exec import rcrix_pkg::*; (
	input wire logic ref_clk, // Core clock
	input wire logic sys_rst, // Async reset, high
	input wire logic instrValid, // Instruction word valid
	input wire logic [15:0] instrWord, // Fetched instruction
	input wire logic nextIsTwoWord, // Following instruction has two words
	input wire logic extendedEnable, // Extended instruction set on
	input wire logic [DA_W-1:0] secondIndexedPointer, // Pointer value
	input wire logic [7:0] dmemRdata, // Data memory read data
	output logic [DA_W-1:0] dmemRaddr, // Data memory read address
	output rcrix_dmem_type dmemWr, // Data memory write
	output rcrix_stack_type returnStackTop, // Return stack push
	output logic [PC_W-1:0] progCounter, // Program counter
	output logic [7:0] workingReg, // W register
	output logic [4:0] statusFlags, // N OV Z DC C
	output logic idleCycle, // Cycle executed as no operation
	output logic resetRequest // Core-wide reset pulse
);
	typedef enum logic [1:0] {EXEC, IDLE1, IDLE2} rcrix_state_type;
	rcrix_state_type state_reg, state_next;
	logic [PC_W-1:0] pc_reg, pc_next;
	logic [7:0] w_reg, w_next;
	logic [4:0] flags_reg, flags_next;
	rcrix_dmem_type dmem_reg, dmem_next;
	rcrix_stack_type stack_reg, stack_next;
	logic [DA_W-1:0] raddr_next;
	logic idle_reg, idle_next, rst_reg, rst_next;

	function automatic logic [DA_W-1:0] effAddr(
		input logic [DA_W-1:0] ptr,
		input logic [6:0] k
	);
		effAddr = ptr + {{(DA_W-7){1'b0}}, k};
	endfunction

	logic [10:0] offN;
	logic [6:0] kOff;
	logic [8:0] sum;
	logic [4:0] lowSum;
	logic [7:0] dec;
	logic idxMode;

	always_comb begin
		offN = instrWord[10:0];
		kOff = instrWord[6:0];
		sum = {1'b0, w_reg} + {1'b0, dmemRdata};
		lowSum = {1'b0, w_reg[3:0]} + {1'b0, dmemRdata[3:0]};
		dec = dmemRdata - 8'h01;
		idxMode = !instrWord[8] && extendedEnable
			&& (instrWord[7:0] <= IDX_LIMIT);
		state_next = state_reg;
		pc_next = pc_reg;
		w_next = w_reg;
		flags_next = flags_reg;
		dmem_next = '{we: 1'b0, addr: dmem_reg.addr, wdata: dmem_reg.wdata};
		stack_next = '{push: 1'b0, value: stack_reg.value};
		raddr_next = effAddr(secondIndexedPointer, kOff);
		idle_next = 1'b0;
		rst_next = 1'b0;
		case (state_reg)
		EXEC: begin
			if (instrValid) begin
				pc_next = pc_reg + 21'h2;
				if (instrWord[15:11] == OP_REL_CALL) begin
					stack_next = '{push: 1'b1, value: pc_reg + 21'h2};
					pc_next = pc_reg + 21'h2
						+ {{9{offN[10]}}, offN, 1'b0};
					state_next = IDLE2;
				end else if (instrWord == OP_RESET) begin
					pc_next = PC_RESET;
					w_next = W_RESET;
					flags_next = FLAGS_RESET;
					rst_next = 1'b1;
				end else if (instrWord[15:10] == OP_ADD_IDX && idxMode) begin
					flags_next[FLAG_C] = sum[8];
					flags_next[FLAG_DC] = lowSum[4];
					flags_next[FLAG_Z] = (sum[7:0] == 8'h00);
					flags_next[FLAG_N] = sum[7];
					flags_next[FLAG_OV] = (w_reg[7] == dmemRdata[7])
						&& (sum[7] != w_reg[7]);
					if (!instrWord[9])
						w_next = sum[7:0];
					else
						dmem_next = '{1'b1, raddr_next, sum[7:0]};
				end else if (instrWord[15:12] == OP_BIT_SET && idxMode) begin
					dmem_next = '{1'b1, raddr_next,
						dmemRdata | (8'h01 << instrWord[11:9])};
				end else if (instrWord[15:8] == OP_FILL_ONES && idxMode) begin
					dmem_next = '{1'b1, raddr_next, ALL_ONES};
				end else if ((instrWord[15:10] == OP_DEC_SKIP_Z
					|| instrWord[15:10] == OP_DEC_SKIP_NZ) && idxMode) begin
					if (!instrWord[9])
						w_next = dec;
					else
						dmem_next = '{1'b1, raddr_next, dec};
					if ((instrWord[15:10] == OP_DEC_SKIP_Z)
						== (dec == 8'h00)) begin
						pc_next = pc_reg + 21'h4;
						state_next = nextIsTwoWord ? IDLE1 : IDLE2;
					end
				end
			end
		end
		IDLE1: begin
			idle_next = 1'b1;
			pc_next = pc_reg + 21'h2;
			state_next = IDLE2;
		end
		default: begin
			idle_next = 1'b1;
			state_next = EXEC;
		end
		endcase
	end

	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_reg <= EXEC;
			pc_reg <= PC_RESET;
			w_reg <= W_RESET;
			flags_reg <= FLAGS_RESET;
			dmem_reg <= '0;
			stack_reg <= '0;
			idle_reg <= 1'b0;
			rst_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			w_reg <= w_next;
			flags_reg <= flags_next;
			dmem_reg <= dmem_next;
			stack_reg <= stack_next;
			idle_reg <= idle_next;
			rst_reg <= rst_next;
		end
	end

	assign dmemRaddr = raddr_next;
	assign dmemWr = dmem_reg;
	assign returnStackTop = stack_reg;
	assign progCounter = pc_reg;
	assign workingReg = w_reg;
	assign statusFlags = flags_reg;
	assign idleCycle = idle_reg;
	assign resetRequest = rst_reg;

	a_call_push: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord[15:11] == OP_REL_CALL)
		|=> returnStackTop.push && returnStackTop.value == $past(pc_reg)
		+ 21'h2 ##1 idleCycle) else $error("call push wrong");
	a_call_target: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord[15:11] == OP_REL_CALL)
		|=> progCounter == $past(pc_reg + 21'h2
		+ {{9{offN[10]}}, offN, 1'b0})) else $error("call target wrong");
	a_reset_clears: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord == OP_RESET)
		|=> progCounter == PC_RESET && workingReg == W_RESET
		&& statusFlags == FLAGS_RESET && resetRequest)
		else $error("reset values wrong");
	a_reset_state: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord == OP_RESET)
		|=> state_reg == EXEC && !dmemWr.we && !returnStackTop.push)
		else $error("reset left activity");
	a_add_result: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord[15:10] == OP_ADD_IDX
		&& idxMode && !instrWord[9]) |=> workingReg == $past(sum[7:0])
		&& !dmemWr.we) else $error("add to W wrong");
	a_add_mem: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord[15:10] == OP_ADD_IDX
		&& idxMode && instrWord[9]) |=> dmemWr.we
		&& dmemWr.wdata == $past(sum[7:0]) && $stable(workingReg))
		else $error("add to file wrong");
	a_bit_set: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord[15:12] == OP_BIT_SET
		&& idxMode) |=> dmemWr.we && dmemWr.wdata[$past(instrWord[11:9])]
		&& $stable(statusFlags)) else $error("bit set wrong");
	a_bit_others: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord[15:12] == OP_BIT_SET
		&& idxMode) |=> dmemWr.wdata == ($past(dmemRdata)
		| (8'h01 << $past(instrWord[11:9])))) else $error("bit set spill");
	a_fill_ones: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && instrWord[15:8] == OP_FILL_ONES
		&& idxMode) |=> dmemWr.we && dmemWr.wdata == ALL_ONES
		&& $stable(statusFlags) && !idleCycle)
		else $error("fill wrong");
	a_skip_idle: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == IDLE1) |=> idleCycle ##1 idleCycle)
		else $error("skip idle wrong");
	a_skip_pc: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == IDLE1) |=> progCounter == $past(pc_reg) + 21'h2)
		else $error("skip count wrong");
	a_idle_refuse: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg != EXEC) |=> !dmemWr.we && !returnStackTop.push
		&& !resetRequest) else $error("work during idle");
	a_idx_gate: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid && !extendedEnable) |=> !dmemWr.we)
		else $error("indexed without extension");
	a_idx_limit: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		(state_reg == EXEC && instrValid
		&& (instrWord[8] || instrWord[7:0] > IDX_LIMIT)) |=> !dmemWr.we)
		else $error("indexed outside offset range");
	a_eff_addr: assert property (
		@(posedge ref_clk) disable iff (sys_rst)
		dmemWr.we |-> dmemWr.addr == $past(secondIndexedPointer)
		+ {{(DA_W-7){1'b0}}, $past(kOff)})
		else $error("effective address wrong");
endmodule

// ---- verif/rcrix_dmem_model.sv ----
/*
 Data memory model for the executer: combinational read, clocked write.
 Assumes the executer's dmemRaddr and dmemWr ports on ref_clk.
*/
`timescale 1ns/1ps
module rcrix_dmem_model import rcrix_pkg::*; (
	input wire logic ref_clk, // Core clock
	input wire logic [DA_W-1:0] dmemRaddr, // Read address
	input wire rcrix_dmem_type dmemWr, // Write request
	output logic [7:0] dmemRdata // Read data
);
	logic [7:0] mem [0:(1<<DA_W)-1];
	assign dmemRdata = mem[dmemRaddr];
	always @(posedge ref_clk) begin
		if (dmemWr.we) begin
			mem[dmemWr.addr] <= dmemWr.wdata;
		end
	end
endmodule

// ---- verif/tb_relative_call_reset_indexed_ops.sv ----
/*
 Testbench for the call, reset and indexed operation executer.
 Assumes the memory model answers reads in the same cycle.
*/
`timescale 1ns/1ps
module tb_relative_call_reset_indexed_ops;
	import rcrix_pkg::*;
	logic ref_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic instrValid = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic twoWord = 1'b0;
	logic extEn = 1'b1;
	logic [DA_W-1:0] ptr = 12'ha00;
	logic [7:0] rdata, w;
	logic [DA_W-1:0] raddr;
	rcrix_dmem_type wr;
	rcrix_stack_type stk;
	logic [PC_W-1:0] pc;
	logic [4:0] flags;
	logic idle, rreq;
	int mismatches = 0;
	int cmp_count = 0;
	always #50 ref_clk = ~ref_clk;
	rcrix_exec uut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.instrValid(instrValid), .instrWord(instrWord),
		.nextIsTwoWord(twoWord), .extendedEnable(extEn),
		.secondIndexedPointer(ptr), .dmemRdata(rdata), .dmemRaddr(raddr),
		.dmemWr(wr), .returnStackTop(stk), .progCounter(pc),
		.workingReg(w), .statusFlags(flags), .idleCycle(idle),
		.resetRequest(rreq));
	rcrix_dmem_model dm (.ref_clk(ref_clk), .dmemRaddr(raddr),
		.dmemWr(wr), .dmemRdata(rdata));
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	task automatic rst();
		sys_rst = 1'b1;
		step(5);
		sys_rst = 1'b0;
	endtask
	task automatic issue(input logic [15:0] word);
		instrValid = 1'b1;
		instrWord = word;
		step(1);
		instrValid = 1'b0;
	endtask
	task automatic t_add();
		rst();
		dm.mem[12'ha2c] = 8'h20;
		dm.mem[12'ha2d] = 8'h17;
		dm.mem[12'ha2e] = 8'he9;
		dm.mem[12'ha2f] = 8'h49;
		dm.mem[12'ha30] = 8'h80;
		issue(16'h242d);
		step(1);
		issue(16'h242c);
		chk(w, 8'h37);
		chk(flags, 5'h00);
		step(1);
		issue(16'h262e);
		chk({wr.we, wr.addr, wr.wdata}, {1'b1, 12'ha2e, 8'h20});
		chk({w, flags}, {8'h37, 5'h03});
		issue(16'h242f);
		chk({w, flags}, {8'h80, 5'h1a});
		issue(16'h2630);
		chk({wr.wdata, w, flags}, {8'h00, 8'h80, 5'h0d});
		step(1);
		$display("Test add done");
	endtask
	task automatic t_bits();
		logic [7:0] e = 8'h00;
		dm.mem[12'ha5f] = 8'h00;
		for (int b = 0; b < 8; b++) begin
			e = e | (8'h01 << b);
			issue(16'h805f | (16'(b) << 9));
			chk({wr.we, wr.addr, wr.wdata}, {1'b1, 12'ha5f, e});
			chk(flags, 5'h0d);
			step(1);
		end
		issue(16'h6800);
		chk({wr.we, wr.addr, wr.wdata}, {1'b1, 12'ha00, 8'hff});
		chk(flags, 5'h0d);
		step(1);
		issue(16'h00ff);
		chk(rreq, 1'b1);
		step(1);
		chk({pc, w, flags}, {PC_RESET, W_RESET, FLAGS_RESET});
		chk(rreq, 1'b0);
		$display("Test bits, fill, reset done");
	endtask
	task automatic t_call();
		rst();
		issue(16'hdbff);
		chk({stk.push, stk.value, pc}, {1'b1, 21'h2, 21'h800});
		step(1);
		chk({idle, stk.push}, 2'b10);
		issue(16'hdc00);
		chk({stk.push, stk.value, pc}, {1'b1, 21'h802, 21'h2});
		step(1);
		$display("Test call done");
	endtask
	task automatic t_skip();
		rst();
		dm.mem[12'ha10] = 8'h01;
		dm.mem[12'ha11] = 8'h05;
		twoWord = 1'b1;
		issue(16'h2e10);
		chk({pc, wr.wdata}, {21'h4, 8'h00});
		step(1);
		chk({pc, idle}, {21'h6, 1'b1});
		step(1);
		chk(idle, 1'b1);
		twoWord = 1'b0;
		step(1);
		issue(16'h4e11);
		chk({pc, wr.wdata}, {21'ha, 8'h04});
		step(1);
		chk(idle, 1'b1);
		step(1);
		chk(idle, 1'b0);
		issue(16'h2e10);
		chk({pc, wr.wdata}, {21'hc, 8'hff});
		step(1);
		chk(idle, 1'b0);
		$display("Test skip done");
	endtask
	task automatic t_mode();
		logic [15:0] ws [3] = '{16'h2600, 16'h2680, 16'h2700};
		rst();
		for (int i = 0; i < 3; i++) begin
			extEn = (i != 0);
			issue(ws[i]);
			chk({wr.we, w, pc}, {1'b0, 8'h00, 21'(2 * (i + 1))});
			step(1);
		end
		extEn = 1'b1;
		$display("Test mode done");
	endtask
	task automatic close_out();
		$display("Compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		t_add();
		t_bits();
		t_call();
		t_skip();
		t_mode();
		close_out();
	end
endmodule
